// file: hdl/cdit_pkg.sv
package cdit_pkg;

    // Link byte clock rate and lane limits.
    localparam int unsigned LNK_CLK_MHZ      = 8;
    localparam int unsigned LANE_MAX_MBPS    = 960;
    localparam int unsigned BITS_PER_BYTE    = 8;
    localparam int unsigned LANE_MBPS        = LNK_CLK_MHZ * BITS_PER_BYTE;

    // Clock lane timing, in nanoseconds.
    localparam int unsigned TCLK_PRE_NS      = 100;
    localparam int unsigned TCLK_POST_NS     = 300;
    localparam int unsigned THS_TRAIL_NS     = 125;

    function automatic int unsigned ns_to_min_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns * LNK_CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int unsigned TCLK_PRE_CYC     = ns_to_min_cyc(TCLK_PRE_NS);
    localparam int unsigned TCLK_POST_CYC    = ns_to_min_cyc(TCLK_POST_NS);
    localparam int unsigned THS_TRAIL_CYC    = ns_to_min_cyc(THS_TRAIL_NS);
    localparam int unsigned TCNT_W           = 6;

    // Buffer shape.
    localparam int unsigned FIFO_DEPTH       = 32;

    // Packet header data types and field layout.
    localparam logic [5:0]  DT_RAW8          = 6'h2A;
    localparam logic [5:0]  DT_RAW10         = 6'h2B;
    localparam int unsigned HDR_VC_LSB       = 6;
    localparam int unsigned SMP_HI_LSB       = 2;

    typedef enum logic [1:0] {
        STRM_SINGLE = 2'b00,
        STRM_SIDE   = 2'b01,
        STRM_STEREO = 2'b10
    } cdit_strm_t;

    typedef struct packed {
        logic       lanes2;
        logic       w10;
        logic       vc_en;
        logic [1:0] vc_base;
        cdit_strm_t strm;
        logic [1:0] rate_div;
    } cdit_cfg_t;

    typedef struct packed {
        logic       sol;
        logic       eol;
        logic       src;
        logic [9:0] smp;
    } cdit_pix_t;

    localparam int unsigned PIX_W            = $bits(cdit_pix_t);

endpackage

// file: hdl/cdit_fifo.sv
`timescale 1ns/1ns
module cdit_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 32
) (
    // Write side.
    input  wire logic         wclk,
    input  wire logic         wrst,
    input  wire logic         wr_valid,
    output logic              wr_ready,
    input  wire logic [W-1:0] wr_data,
    // Read side.
    input  wire logic         rclk,
    input  wire logic         rrst,
    output logic              rd_valid,
    input  wire logic         rd_ready,
    output logic [W-1:0]      rd_data
);
    localparam int unsigned AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wbin_r, rbin_r, wgray_r, rgray_r;
    logic [AW:0]  rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
    logic [AW:0]  wbin_nxt, rbin_nxt, wgray_nxt, rgray_nxt;

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    assign wbin_nxt  = wbin_r + (AW+1)'(wr_valid && wr_ready);
    assign rbin_nxt  = rbin_r + (AW+1)'(rd_valid && rd_ready);
    assign wgray_nxt = bin2gray(wbin_nxt);
    assign rgray_nxt = bin2gray(rbin_nxt);
    assign rd_data   = mem[rbin_r[AW-1:0]];

    always_ff @(posedge wclk) begin
        if (wr_valid && wr_ready) begin
            mem[wbin_r[AW-1:0]] <= wr_data;
        end
    end

    // Full is registered so that the ready seen by the source comes from a flop.
    always_ff @(posedge wclk or posedge wrst) begin
        if (wrst) begin
            wbin_r   <= '0;
            wgray_r  <= '0;
            rg_s1_r  <= '0;
            rg_s2_r  <= '0;
            wr_ready <= 1'b0;
        end else begin
            wbin_r   <= wbin_nxt;
            wgray_r  <= wgray_nxt;
            rg_s1_r  <= rgray_r;
            rg_s2_r  <= rg_s1_r;
            wr_ready <= wgray_nxt != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]};
        end
    end

    always_ff @(posedge rclk or posedge rrst) begin
        if (rrst) begin
            rbin_r   <= '0;
            rgray_r  <= '0;
            wg_s1_r  <= '0;
            wg_s2_r  <= '0;
            rd_valid <= 1'b0;
        end else begin
            rbin_r   <= rbin_nxt;
            rgray_r  <= rgray_nxt;
            wg_s1_r  <= wgray_r;
            wg_s2_r  <= wg_s1_r;
            rd_valid <= rgray_nxt != wg_s2_r;
        end
    end

endmodule // cdit_fifo

// file: hdl/cdit_tx.sv
`timescale 1ns/1ns
module cdit_tx
    import cdit_pkg::*;
(
    // System clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Link byte clock.
    input  wire logic       lnk_clk,
    // Static configuration, system domain.
    input  wire cdit_cfg_t  cfg,
    // Pixel stream in.
    input  wire logic       pix_valid,
    output logic            pix_ready,
    input  wire cdit_pix_t  pix,
    // Clock lane.
    output logic            cl_hs_r,
    output logic            cl_run_r,
    // Data lanes.
    output logic [1:0]      dl_req_r,
    output logic [1:0]      dl_vld_r,
    output logic [1:0][7:0] dl_byte_r
);

    typedef enum logic [2:0] {
        L_IDLE   = 3'b000,
        L_WAKE   = 3'b001,
        L_HDR    = 3'b010,
        L_PAY_HI = 3'b011,
        L_PAY_LO = 3'b100,
        L_FT0    = 3'b101,
        L_FT1    = 3'b110
    } cdit_lst_t;

    typedef enum logic [2:0] {
        C_LP    = 3'b000,
        C_PRE   = 3'b001,
        C_HS    = 3'b010,
        C_POST  = 3'b011,
        C_TRAIL = 3'b100
    } cdit_cst_t;

    logic        lrst_s1_r, lrst_r;
    cdit_cfg_t   cfg_s1_r, cfg_s_r;
    logic        rd_valid, rd_ready;
    cdit_pix_t   head;
    logic [PIX_W-1:0] rd_raw;
    cdit_lst_t   lst_r, lst_nxt;
    cdit_cst_t   cst_r, cst_nxt;
    logic [TCNT_W-1:0] tcnt_r;
    logic [1:0]  rate_cnt_r;
    logic        tick, emit;
    logic [7:0]  emit_b;
    logic [1:0]  vc_r;
    logic [7:0]  xor_r;
    logic        lane_r;
    logic [1:0]  end_r;

    function automatic logic [1:0] pick_vc(input cdit_cfg_t c, input logic src);
        if (!c.vc_en) begin
            return 2'h0;
        end
        if (c.strm == STRM_STEREO) begin
            return c.vc_base + {1'b0, src};
        end
        return c.vc_base;
    endfunction

    // The link side has its own reset release so that no flop there leaves reset on a torn edge.
    always_ff @(posedge lnk_clk or posedge rst) begin
        if (rst) begin
            lrst_s1_r <= 1'b1;
            lrst_r    <= 1'b1;
        end else begin
            lrst_s1_r <= 1'b0;
            lrst_r    <= lrst_s1_r;
        end
    end

    // Configuration is meant to be static while bursts run; the two flops only keep it metastable-safe.
    always_ff @(posedge lnk_clk or posedge lrst_r) begin
        if (lrst_r) begin
            cfg_s1_r <= '0;
            cfg_s_r  <= '0;
        end else begin
            cfg_s1_r <= cfg;
            cfg_s_r  <= cfg_s1_r;
        end
    end

    cdit_fifo #(
        .W (PIX_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .wclk     (clk),
        .wrst     (rst),
        .wr_valid (pix_valid),
        .wr_ready (pix_ready),
        .wr_data  (pix),
        .rclk     (lnk_clk),
        .rrst     (lrst_r),
        .rd_valid (rd_valid),
        .rd_ready (rd_ready),
        .rd_data  (rd_raw)
    );

    assign head = cdit_pix_t'(rd_raw);

    // Byte pacing sets the lane bit rate at or below the byte clock ceiling; rate_div 0 sends a byte every clock.
    assign tick = (rate_cnt_r == 2'h0);

    always_ff @(posedge lnk_clk or posedge lrst_r) begin
        if (lrst_r) begin
            rate_cnt_r <= 2'h0;
        end else if (tick) begin
            rate_cnt_r <= cfg_s_r.rate_div;
        end else begin
            rate_cnt_r <= rate_cnt_r - 2'h1;
        end
    end

    // Packet sequencer: header, payload, two footer bytes per line.
    always_comb begin
        lst_nxt  = lst_r;
        emit     = 1'b0;
        emit_b   = 8'h00;
        rd_ready = 1'b0;
        unique case (lst_r)
            L_IDLE: begin
                if (rd_valid && !head.sol) begin
                    rd_ready = 1'b1;
                end else if (rd_valid) begin
                    lst_nxt = L_WAKE;
                end
            end
            L_WAKE: begin
                if (cst_r == C_HS) begin
                    lst_nxt = L_HDR;
                end
            end
            L_HDR: begin
                if (tick) begin
                    emit    = 1'b1;
                    emit_b  = {vc_r, cfg_s_r.w10 ? DT_RAW10 : DT_RAW8};
                    lst_nxt = L_PAY_HI;
                end
            end
            L_PAY_HI: begin
                // A starved buffer stalls the byte strobes; the lane stays in HS meanwhile.
                if (tick && rd_valid) begin
                    emit   = 1'b1;
                    emit_b = head.smp[$bits(head.smp)-1:SMP_HI_LSB];
                    if (cfg_s_r.w10) begin
                        lst_nxt = L_PAY_LO;
                    end else begin
                        rd_ready = 1'b1;
                        lst_nxt  = head.eol ? L_FT0 : L_PAY_HI;
                    end
                end
            end
            L_PAY_LO: begin
                if (tick) begin
                    emit     = 1'b1;
                    emit_b   = {6'h00, head.smp[SMP_HI_LSB-1:0]};
                    rd_ready = 1'b1;
                    lst_nxt  = head.eol ? L_FT0 : L_PAY_HI;
                end
            end
            L_FT0: begin
                if (tick) begin
                    emit    = 1'b1;
                    emit_b  = xor_r;
                    lst_nxt = L_FT1;
                end
            end
            L_FT1: begin
                if (tick) begin
                    emit    = 1'b1;
                    emit_b  = ~xor_r;
                    lst_nxt = L_IDLE;
                end
            end
            default: begin
                lst_nxt = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge lnk_clk or posedge lrst_r) begin
        if (lrst_r) begin
            lst_r <= L_IDLE;
        end else begin
            lst_r <= lst_nxt;
        end
    end

    always_ff @(posedge lnk_clk or posedge lrst_r) begin
        if (lrst_r) begin
            vc_r <= 2'h0;
        end else if (lst_r == L_IDLE && rd_valid && head.sol) begin
            vc_r <= pick_vc(cfg_s_r, head.src);
        end
    end

    always_ff @(posedge lnk_clk or posedge lrst_r) begin
        if (lrst_r) begin
            xor_r <= 8'h00;
        end else if (lst_r == L_WAKE) begin
            xor_r <= 8'h00;
        end else if (emit && (lst_r == L_PAY_HI || lst_r == L_PAY_LO)) begin
            xor_r <= xor_r ^ emit_b;
        end
    end

    // Lane distribution and byte strobes.
    always_ff @(posedge lnk_clk or posedge lrst_r) begin
        if (lrst_r) begin
            lane_r    <= 1'b0;
            dl_vld_r  <= 2'b00;
            dl_byte_r <= '0;
        end else begin
            dl_vld_r <= 2'b00;
            if (lst_r == L_WAKE) begin
                lane_r <= 1'b0;
            end else if (emit) begin
                dl_byte_r[lane_r] <= emit_b;
                dl_vld_r[lane_r]  <= 1'b1;
                lane_r            <= cfg_s_r.lanes2 ? ~lane_r : 1'b0;
            end
        end
    end

    // Each lane ends its burst after its own last byte, so lanes may finish apart.
    always_ff @(posedge lnk_clk or posedge lrst_r) begin
        if (lrst_r) begin
            dl_req_r <= 2'b00;
            end_r    <= 2'b00;
        end else begin
            end_r <= 2'b00;
            if (emit && (lst_r == L_FT1 || (lst_r == L_FT0 && cfg_s_r.lanes2))) begin
                end_r[lane_r] <= 1'b1;
            end
            if (lst_r == L_WAKE && cst_r == C_HS) begin
                dl_req_r <= cfg_s_r.lanes2 ? 2'b11 : 2'b01;
            end else begin
                dl_req_r <= dl_req_r & ~end_r;
            end
        end
    end

    // Clock lane sequencing.
    always_comb begin
        cst_nxt = cst_r;
        unique case (cst_r)
            C_LP: begin
                if (lst_r == L_WAKE) begin
                    cst_nxt = C_PRE;
                end
            end
            C_PRE: begin
                if (tcnt_r == TCNT_W'(TCLK_PRE_CYC - 1)) begin
                    cst_nxt = C_HS;
                end
            end
            C_HS: begin
                if (lst_r == L_IDLE && dl_req_r == 2'b00 && end_r == 2'b00) begin
                    cst_nxt = C_POST;
                end
            end
            C_POST: begin
                if (lst_r != L_IDLE) begin
                    cst_nxt = C_HS;
                end else if (tcnt_r == TCNT_W'(TCLK_POST_CYC - 1)) begin
                    cst_nxt = C_TRAIL;
                end
            end
            C_TRAIL: begin
                if (tcnt_r == TCNT_W'(THS_TRAIL_CYC - 1)) begin
                    cst_nxt = C_LP;
                end
            end
            default: begin
                cst_nxt = C_LP;
            end
        endcase
    end

    always_ff @(posedge lnk_clk or posedge lrst_r) begin
        if (lrst_r) begin
            cst_r  <= C_LP;
            tcnt_r <= '0;
        end else begin
            cst_r  <= cst_nxt;
            tcnt_r <= (cst_nxt != cst_r) ? '0 : tcnt_r + TCNT_W'(1);
        end
    end

    // The DDR clock toggles through PRE, HS and POST; TRAIL holds HS-0 before the lane drops to LP.
    always_ff @(posedge lnk_clk or posedge lrst_r) begin
        if (lrst_r) begin
            cl_hs_r  <= 1'b0;
            cl_run_r <= 1'b0;
        end else begin
            cl_hs_r  <= cst_nxt != C_LP;
            cl_run_r <= cst_nxt == C_PRE || cst_nxt == C_HS || cst_nxt == C_POST;
        end
    end

    a_lane_one_idle: assert property (@(posedge lnk_clk) disable iff (lrst_r)
        !cfg_s_r.lanes2 |-> !dl_req_r[1] && !dl_vld_r[1])
        else $error("Lane 1 active in one-lane mode");

    a_width_low_byte: assert property (@(posedge lnk_clk) disable iff (lrst_r)
        (emit && lst_r == L_PAY_LO) |-> cfg_s_r.w10 ##1 (dl_byte_r[$past(lane_r)][7:2] == 6'h00))
        else $error("Low sample byte wrong or sent in 8-bit mode");

    a_rate_pace: assert property (@(posedge lnk_clk) disable iff (lrst_r)
        (emit && cfg_s_r.rate_div == 2'h1) |=> !emit)
        else $error("Byte pacing too fast");

    a_vc_off_zero: assert property (@(posedge lnk_clk) disable iff (lrst_r)
        (emit && lst_r == L_HDR && !cfg_s_r.vc_en) |=> dl_byte_r[0][7:6] == 2'h0)
        else $error("Channel tag present with channels off");

    a_vc_stereo_tag: assert property (@(posedge lnk_clk) disable iff (lrst_r)
        (lst_r == L_IDLE && rd_valid && head.sol && cfg_s_r.vc_en && cfg_s_r.strm == STRM_STEREO)
        |=> vc_r == $past(cfg_s_r.vc_base) + {1'b0, $past(head.src)})
        else $error("Stereo channel tag wrong");

    a_hdr_lane_zero: assert property (@(posedge lnk_clk) disable iff (lrst_r)
        (emit && lst_r == L_HDR) |=> dl_vld_r == 2'b01 ##[1:4] dl_vld_r[1] || !cfg_s_r.lanes2)
        else $error("Header not on lane 0 or lane 1 unused");

    a_clk_before_data: assert property (@(posedge lnk_clk) disable iff (lrst_r)
        $rose(dl_req_r[0]) |-> cl_hs_r && cl_run_r && $past(cst_r) == C_HS)
        else $error("Data burst began without HS clock");

    a_clk_stop_idle: assert property (@(posedge lnk_clk) disable iff (lrst_r)
        $fell(cl_run_r) |-> dl_req_r == 2'b00 && cl_hs_r)
        else $error("Clock stopped with data active or not in HS-0");

    a_run_needs_hs: assert property (@(posedge lnk_clk) disable iff (lrst_r)
        cl_run_r |-> cl_hs_r)
        else $error("Clock toggling outside HS");

    a_post_hold: assert property (@(posedge lnk_clk) disable iff (lrst_r)
        (cst_r == C_HS && cst_nxt == C_POST) |=> cl_run_r [*2])
        else $error("Clock stopped before post interval");

    c_two_lane_pkt: cover property (@(posedge lnk_clk) disable iff (lrst_r)
        cfg_s_r.lanes2 && $fell(dl_req_r[1]) && dl_req_r[0]);

    c_ten_bit_pkt: cover property (@(posedge lnk_clk) disable iff (lrst_r)
        emit && lst_r == L_PAY_LO && head.eol);

    c_clk_cycle: cover property (@(posedge lnk_clk) disable iff (lrst_r)
        cst_r == C_TRAIL ##1 cst_r == C_LP);

endmodule // cdit_tx

// file: dv/cdit_rx_model.sv
`timescale 1ns/1ns
module cdit_rx_model
    import cdit_pkg::*;
(
    // Link side seen from the receiver.
    input wire logic            lnk_clk,
    input wire logic            rst,
    input wire logic            lanes2,
    input wire logic [1:0]      rate_div,
    input wire logic            cl_hs_r,
    input wire logic            cl_run_r,
    input wire logic [1:0]      dl_req_r,
    input wire logic [1:0]      dl_vld_r,
    input wire logic [1:0][7:0] dl_byte_r
);
    int         bad;
    int         gap;
    int         post;
    logic [1:0] req_d;
    logic       run_d;
    logic       hs_d;
    logic [7:0] q0[$];
    logic [7:0] q1[$];
    logic [7:0] rx_bytes[$];
    int         rx_len[$];

    // The receiver only listens, so it cannot slow the link; it only judges it.
    always @(posedge lnk_clk or posedge rst) begin
        if (rst) begin
            bad = 0;
            gap = 99;
            post = 0;
            req_d = 2'h0;
            run_d = 1'b0;
            hs_d = 1'b0;
        end else begin
            if (dl_vld_r != 2'h0 && !(cl_hs_r && cl_run_r)) bad++;
            if (dl_req_r != 2'h0 && !cl_run_r) bad++;
            if (!lanes2 && (dl_req_r[1] || dl_vld_r[1])) bad++;
            if (lanes2 && req_d == 2'h0 && dl_req_r != 2'h0 && dl_req_r != 2'h3) bad++;
            gap = dl_req_r[0] ? gap + 1 : 99;
            if (dl_vld_r[0]) begin
                if (gap <= rate_div) bad++;
                gap = 0;
            end
            if (dl_vld_r[0]) q0.push_back(dl_byte_r[0]);
            if (dl_vld_r[1]) q1.push_back(dl_byte_r[1]);
            if (req_d != 2'h0 && dl_req_r == 2'h0) begin
                rx_len.push_back(q0.size() + q1.size());
                while (q0.size() > 0) begin
                    rx_bytes.push_back(q0.pop_front());
                    if (q1.size() > 0) rx_bytes.push_back(q1.pop_front());
                end
                if (q1.size() > 0) bad++;
                q1.delete();
                post = 0;
            end
            if (dl_req_r == 2'h0 && cl_run_r) post++;
            if (run_d && !cl_run_r && (post < TCLK_POST_CYC || !cl_hs_r)) bad++;
            if (hs_d && !cl_hs_r && run_d) bad++;
            req_d = dl_req_r;
            run_d = cl_run_r;
            hs_d = cl_hs_r;
        end
    end
endmodule // cdit_rx_model

// file: dv/cdit_tx_bench.sv
`timescale 1ns/1ns
module cdit_tx_bench;
    import cdit_pkg::*;
    logic             clk = 1'b0;
    logic             lnk_clk = 1'b0;
    logic             rst = 1'b0;
    cdit_cfg_t        cfg = '0;
    logic             pix_valid = 1'b0;
    cdit_pix_t        pix = '0;
    logic             pix_ready;
    logic             cl_hs_r;
    logic             cl_run_r;
    logic [1:0]       dl_req_r;
    logic [1:0]       dl_vld_r;
    logic [1:0][7:0]  dl_byte_r;
    logic             saw_full = 1'b0;
    int               errors = 0;
    int               check_count = 0;
    logic [7:0]       exp_b[$];
    int               exp_len[$];

    always #2 clk = ~clk;
    // The link clock is offset so its edges drift against the system clock.
    initial begin
        #7;
        forever begin
            #62 lnk_clk = ~lnk_clk;
            #63 lnk_clk = ~lnk_clk;
        end
    end

    cdit_tx i_dut (.clk(clk), .rst(rst), .lnk_clk(lnk_clk), .cfg(cfg), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix(pix), .cl_hs_r(cl_hs_r), .cl_run_r(cl_run_r),
        .dl_req_r(dl_req_r), .dl_vld_r(dl_vld_r), .dl_byte_r(dl_byte_r));

    cdit_rx_model i_rx (.lnk_clk(lnk_clk), .rst(rst), .lanes2(cfg.lanes2), .rate_div(cfg.rate_div),
        .cl_hs_r(cl_hs_r), .cl_run_r(cl_run_r), .dl_req_r(dl_req_r), .dl_vld_r(dl_vld_r),
        .dl_byte_r(dl_byte_r));

    always @(negedge clk) if (pix_valid && pix_ready === 1'b0) saw_full <= 1'b1;

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", what, e, g);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Called at a rising edge; returns at the edge that takes the pixel.
    task automatic send(input cdit_pix_t p);
        int n;
        n = 0;
        pix_valid <= 1'b1;
        pix <= p;
        do begin
            @(negedge clk);
            n++;
        end while (pix_ready !== 1'b1 && n < 5000);
        if (n >= 5000) errors++;
        @(posedge clk);
    endtask

    task automatic line(input int len, input logic src);
        logic [7:0] x;
        logic [1:0] vc;
        cdit_pix_t  p;
        int         nb;
        vc = !cfg.vc_en ? 2'h0 : (cfg.strm == STRM_STEREO ? cfg.vc_base + 2'(src) : cfg.vc_base);
        exp_b.push_back({vc, cfg.w10 ? DT_RAW10 : DT_RAW8});
        x = 8'h00;
        nb = 0;
        for (int i = 0; i < len; i++) begin
            p.sol = (i == 0);
            p.eol = (i == len - 1);
            p.src = src;
            p.smp = 10'($urandom);
            send(p);
            exp_b.push_back(p.smp[9:2]);
            x ^= p.smp[9:2];
            nb++;
            if (cfg.w10) begin
                exp_b.push_back({6'h00, p.smp[1:0]});
                x ^= {6'h00, p.smp[1:0]};
                nb++;
            end
        end
        exp_b.push_back(x);
        exp_b.push_back(~x);
        exp_len.push_back(nb + 3);
    endtask

    initial begin
        int n;
        int el;
        void'($urandom(32'hEFB0));
        // Reset rises as a real edge, because the link side sees no clock edge while it is held.
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("dl_req_idle", 0, dl_req_r);
        for (int k = 0; k < 12; k++) begin
            cfg <= '{lanes2: 1'(k), w10: 1'(k >> 1), vc_en: 1'($urandom % 4 != 0), vc_base: 2'($urandom),
                     strm: cdit_strm_t'(k / 4), rate_div: 2'($urandom)};
            repeat (4) @(posedge lnk_clk);
            @(posedge clk);
            if (k == 3) send('{sol: 1'b0, eol: 1'b1, src: 1'b0, smp: 10'h3FF});
            line((k == 11) ? 40 : 1 + $urandom % 8, 1'($urandom));
            line(1 + $urandom % 8, 1'($urandom));
            pix_valid <= 1'b0;
            n = 0;
            while ((i_rx.rx_len.size() < 2 || cl_hs_r !== 1'b0) && n < 3000) begin
                @(posedge lnk_clk);
                n++;
            end
            chk("packets", 2, i_rx.rx_len.size());
            while (exp_len.size() > 0) begin
                el = exp_len.pop_front();
                chk("length", el, (i_rx.rx_len.size() > 0) ? i_rx.rx_len.pop_front() : -1);
                for (int j = 0; j < el; j++) begin
                    chk("byte", exp_b.pop_front(), (i_rx.rx_bytes.size() > 0) ? i_rx.rx_bytes.pop_front() : 'x);
                end
            end
            i_rx.rx_bytes.delete();
            @(posedge clk);
        end
        chk("fifo_full_seen", 1, saw_full);
        chk("link_faults", 0, i_rx.bad);
        summarize;
    end

    initial begin
        #360000;
        errors++;
        summarize;
    end
endmodule // cdit_tx_bench
